// File: crcsr_pkg.sv
// Constants, types and field layout for the CRC status and config-one register logic.
// Assumes a command decoder outside that presents one decoded register request per cycle.
// Function
// - Pause command during CRC sets suspended flag
// - Continue command clears the suspended flag
// - Suspended flag read-only, cleared by all resets
// - Abort CRC when end below start plus three
// - Abort flag cleared on good start, resets
// - Four config registers, volatile plus nonvolatile
// - Power-up and hardware reset load volatile
// - Control logic uses only volatile copies
// - Nonvolatile write updates both copies at once
// - Config reads return volatile contents, zero while busy
// - Write address picks nonvolatile or volatile
// - Config one readable at both addresses
// - Bits seven to four hold latency code
// - Bit one selects quad I/O mode
// - Factory default zero, reserved bits read zero
// - Status two read-only at its addresses
// - Busy flag while CRC is running or paused
// - Each latency cycle is one full SCK
package crcsr_pkg;
  localparam int ADDR_W = 24;
  localparam int ADDR_MEM_W = 18;
  // Register addresses for the generic register commands
  localparam logic [23:0] ADDR_SR2_NV = 24'h00_0001;
  localparam logic [23:0] ADDR_SR2_V = 24'h07_0001;
  localparam logic [23:0] ADDR_CR1_NV = 24'h00_0002;
  localparam logic [23:0] ADDR_CR1_V = 24'h07_0002;
  // Field positions
  localparam int SR2_SUSP_BIT = 4;
  localparam int SR2_ABRT_BIT = 3;
  localparam int CR1_QUAD_BIT = 1;
  localparam int CR1_LAT_LO = 4;
  // Writable bits of config one: latency code and quad
  localparam logic [7:0] CR1_WMASK = 8'hF2;
  localparam logic [7:0] CR_FACTORY = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Minimum span between end and start of a CRC range
  localparam logic [17:0] CRC_MIN_SPAN = 18'h0_0003;
  localparam int NUM_CR = 4;
  // Dedicated command codes presented by the decoder
  typedef enum logic [2:0] {
    CRCSR_CMD_NONE = 3'b000,
    CRCSR_CMD_WRITE_ANY = 3'b001,
    CRCSR_CMD_READ_ANY = 3'b010,
    CRCSR_CMD_READ_CR1 = 3'b011,
    CRCSR_CMD_READ_SR2 = 3'b100,
    CRCSR_CMD_CRC_START = 3'b101,
    CRCSR_CMD_CRC_PAUSE = 3'b110,
    CRCSR_CMD_CRC_CONT = 3'b111
  } crcsr_cmd_e;
  // One decoded register request
  typedef struct packed {
    logic valid;
    crcsr_cmd_e cmd;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic [17:0] start_addr;
    logic [17:0] end_addr;
  } crcsr_req_s;
  // Read answer
  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } crcsr_rsp_s;
  // CRC engine sequence states
  typedef enum logic [1:0] {
    CRCSR_IDLE = 2'b00,
    CRCSR_RUN = 2'b01,
    CRCSR_PAUSED = 2'b10
  } crcsr_state_e;
endpackage

// File: crcsr_cfg_copy.sv
// Volatile/nonvolatile pair for one configuration register.
// Assumes the nonvolatile store is retained outside reset; reload pulse comes from the top.
`timescale 1ns/1ps
`default_nettype none
module crcsr_cfg_copy
  import crcsr_pkg::*;
#(
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reload,
  input wire logic wr_nv,
  input wire logic wr_v,
  input wire logic [7:0] wdata,
  output logic [7:0] vol_q,
  output logic [7:0] nv_q
);
  // Masked write value so reserved bits never store
  wire [7:0] wmasked = wdata & WMASK;
  logic [7:0] vol_ff;
  logic [7:0] nv_ff;
  wire [7:0] nxt_vol = reload ? nv_ff : ((wr_nv | wr_v) ? wmasked : vol_ff);
  wire [7:0] nxt_nv = wr_nv ? wmasked : nv_ff;

  // Nonvolatile copy; its reset value models the factory contents only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_ff <= CR_FACTORY;
    end else begin
      nv_ff <= nxt_nv;
    end
  end

  // Volatile copy: loaded from the nonvolatile copy on reload
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vol_ff <= CR_FACTORY;
    end else begin
      vol_ff <= nxt_vol;
    end
  end

  assign vol_q = vol_ff;
  assign nv_q = nv_ff;

  AST_NV_WRITE_BOTH: assert property (@(posedge clk) disable iff (!reset_n)
    wr_nv && !reload |=> (vol_q == nv_q) && (nv_q == $past(wmasked)))
    else $error("nonvolatile write did not update both copies");
  AST_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
    reload |=> vol_q == $past(nv_q))
    else $error("reload did not copy nonvolatile value");
endmodule
`default_nettype wire

// File: crcsr_top.sv
// Status-two CRC flags, config registers and read mux of the serial memory.
// Assumes requests come decoded, one per cycle, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module crcsr_top
  import crcsr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_reset_pulse,
  input wire logic sw_reset_pulse,
  input wire logic crc_done,
  input var crcsr_req_s req,
  output crcsr_rsp_s rsp,
  output logic busy_flag,
  output logic [3:0] read_latency_code,
  output logic quad_io_en,
  output logic crc_running,
  output logic crc_start_ok,
  output logic [7:0] status_reg_two
);
  // Decoded command strobes
  wire is_req = req.valid;
  wire cmd_wr = is_req && (req.cmd == CRCSR_CMD_WRITE_ANY);
  wire cmd_rd = is_req && (req.cmd == CRCSR_CMD_READ_ANY);
  wire cmd_rcr = is_req && (req.cmd == CRCSR_CMD_READ_CR1);
  wire cmd_rsr = is_req && (req.cmd == CRCSR_CMD_READ_SR2);
  wire cmd_start = is_req && (req.cmd == CRCSR_CMD_CRC_START);
  wire cmd_pause = is_req && (req.cmd == CRCSR_CMD_CRC_PAUSE);
  wire cmd_cont = is_req && (req.cmd == CRCSR_CMD_CRC_CONT);

  // Reset events that clear volatile status
  wire any_reset = hw_reset_pulse | sw_reset_pulse;

  // Address match helpers for config one and status two
  function automatic logic addr_is_cr1(input logic [23:0] a);
    addr_is_cr1 = (a == ADDR_CR1_NV) || (a == ADDR_CR1_V);
  endfunction
  function automatic logic addr_is_sr2(input logic [23:0] a);
    addr_is_sr2 = (a == ADDR_SR2_NV) || (a == ADDR_SR2_V);
  endfunction

  // CRC sequence state
  crcsr_state_e state_ff;
  crcsr_state_e nxt_state;
  logic susp_ff;
  logic abrt_ff;

  // Range test: end must reach at least start plus three
  wire [18:0] span_sum = {1'b0, req.start_addr} + {1'b0, CRC_MIN_SPAN};
  wire range_bad = {1'b0, req.end_addr} < span_sum;
  wire start_take = cmd_start && (state_ff == CRCSR_IDLE);
  wire start_good = start_take && !range_bad;
  wire start_fail = start_take && range_bad;
  wire pause_take = cmd_pause && (state_ff == CRCSR_RUN);
  wire cont_take = cmd_cont && (state_ff == CRCSR_PAUSED);
  // Config writes and config reads are ignored while the engine is busy
  wire idle_now = (state_ff == CRCSR_IDLE);

  // Next state of the CRC sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CRCSR_IDLE: begin
        if (start_good) begin
          nxt_state = CRCSR_RUN;
        end
      end
      CRCSR_RUN: begin
        if (pause_take) begin
          nxt_state = CRCSR_PAUSED;
        end else if (crc_done) begin
          nxt_state = CRCSR_IDLE;
        end
      end
      CRCSR_PAUSED: begin
        if (cont_take) begin
          nxt_state = CRCSR_RUN;
        end
      end
      default: begin
        nxt_state = CRCSR_IDLE;
      end
    endcase
  end

  // State register; software or hardware reset returns to idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= CRCSR_IDLE;
    end else begin
      state_ff <= any_reset ? CRCSR_IDLE : nxt_state;
    end
  end

  // Suspended flag: pause sets, continue clears, resets clear
  wire nxt_susp = any_reset ? 1'b0 : (pause_take ? 1'b1 : (cont_take ? 1'b0 : susp_ff));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      susp_ff <= 1'b0;
    end else begin
      susp_ff <= nxt_susp;
    end
  end

  // Aborted flag: bad range sets, good start clears, resets clear
  wire nxt_abrt = any_reset ? 1'b0 : (start_fail ? 1'b1 : (start_good ? 1'b0 : abrt_ff));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abrt_ff <= 1'b0;
    end else begin
      abrt_ff <= nxt_abrt;
    end
  end

  // Busy only while the calculation executes, paused included
  assign busy_flag = (state_ff != CRCSR_IDLE);
  assign crc_running = (state_ff == CRCSR_RUN);
  assign crc_start_ok = start_good;

  // Status two: only the two flags, all other bits zero
  wire [7:0] sr2_val = (BYTE_ZERO | ({7'h00, susp_ff} << SR2_SUSP_BIT))
                     | ({7'h00, abrt_ff} << SR2_ABRT_BIT);
  assign status_reg_two = sr2_val;

  // Config one write decode; writes to status two fall through and are ignored
  wire cr1_wr_nv = cmd_wr && idle_now && (req.addr == ADDR_CR1_NV);
  wire cr1_wr_v = cmd_wr && idle_now && (req.addr == ADDR_CR1_V);

  // Volatile reload after power-up release and on hardware reset
  logic boot_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end
  wire reload = boot_ff | hw_reset_pulse;

  // Four configuration register pairs; only config one has writable fields here
  logic [7:0] cr_vol [NUM_CR];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CR; gi++) begin : g_cr
      localparam logic [7:0] MASK_I = (gi == 0) ? CR1_WMASK : BYTE_ZERO;
      crcsr_cfg_copy #(
        .WMASK(MASK_I)
      ) u_copy (
        .clk(clk),
        .reset_n(reset_n),
        .reload(reload),
        .wr_nv((gi == 0) ? cr1_wr_nv : 1'b0),
        .wr_v((gi == 0) ? cr1_wr_v : 1'b0),
        .wdata(req.wdata),
        .vol_q(cr_vol[gi]),
        .nv_q()
      );
    end
  endgenerate

  // Control outputs derive from volatile contents only
  wire [7:0] cr1_vol = cr_vol[0];
  logic [3:0] lat_ff;
  logic quad_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_ff <= 4'h0;
      quad_ff <= 1'b0;
    end else begin
      lat_ff <= cr1_vol[CR1_LAT_LO +: 4];
      quad_ff <= cr1_vol[CR1_QUAD_BIT];
    end
  end
  // Latency counts whole SCK periods in the serial front end
  assign read_latency_code = lat_ff;
  assign quad_io_en = quad_ff;

  // Read mux: status two allowed while busy, config reads only when idle
  wire rd_sr2 = cmd_rsr || (cmd_rd && addr_is_sr2(req.addr));
  wire rd_cr1 = idle_now && (cmd_rcr || (cmd_rd && addr_is_cr1(req.addr)));
  wire rd_any = cmd_rsr || cmd_rcr || cmd_rd;
  wire [7:0] rd_mux = rd_sr2 ? sr2_val : (rd_cr1 ? cr1_vol : BYTE_ZERO);

  // Registered answer, one cycle after the request
  crcsr_rsp_s rsp_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= rd_any;
      rsp_ff.hit <= rd_sr2 | rd_cr1;
      rsp_ff.data <= rd_mux;
    end
  end
  assign rsp = rsp_ff;

  AST_SUSP_SET: assert property (@(posedge clk) disable iff (!reset_n)
    pause_take && !any_reset |=> status_reg_two[SR2_SUSP_BIT] && !crc_running)
    else $error("pause did not set suspended flag");
  AST_SUSP_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    cont_take && !any_reset |=> !status_reg_two[SR2_SUSP_BIT] && crc_running)
    else $error("continue did not clear suspended flag");
  AST_RST_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    any_reset |=> status_reg_two == BYTE_ZERO && !busy_flag)
    else $error("reset did not clear status two");
  AST_ABORT: assert property (@(posedge clk) disable iff (!reset_n)
    start_fail && !any_reset |=> status_reg_two[SR2_ABRT_BIT] && !busy_flag)
    else $error("bad range did not abort");
  AST_ABORT_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    start_good && !any_reset |=> !status_reg_two[SR2_ABRT_BIT] && busy_flag)
    else $error("good start did not clear abort flag");
  AST_RD_CR1: assert property (@(posedge clk) disable iff (!reset_n)
    rd_cr1 && !rd_sr2 |=> rsp.valid && rsp.data == $past(cr1_vol))
    else $error("config read did not return volatile contents");
  AST_RESERVED: assert property (@(posedge clk) disable iff (!reset_n)
    (cr1_vol & ~CR1_WMASK) == BYTE_ZERO && (status_reg_two & 8'hE7) == BYTE_ZERO)
    else $error("reserved bit read nonzero");
  AST_CTRL_VOL: assert property (@(posedge clk) disable iff (!reset_n)
    cr1_wr_v && !reload |=> ##1 quad_io_en == $past(req.wdata[CR1_QUAD_BIT], 2))
    else $error("control did not follow volatile write");
  AST_BUSY: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy_flag) |-> $past(start_good))
    else $error("busy set without CRC start");
endmodule
`default_nettype wire

// File: crcsr_host_model.sv
// Behavioural host that presents one decoded register request at a time.
// Assumes the design takes a request on the rising clock edge while valid is high.
`timescale 1ns/1ps
`default_nettype none
module crcsr_host_model
  import crcsr_pkg::*;
(
  input wire logic clk,
  output crcsr_req_s req
);
  // Idle request at time zero
  initial begin
    req = '0;
  end

  // Drive one request at a falling edge, hold it over one rising edge, then release
  task automatic issue(input crcsr_cmd_e c, input logic [23:0] a, input logic [7:0] w,
                       input logic [17:0] s, input logic [17:0] e);
    @(negedge clk);
    req.valid = 1'b1;
    req.cmd = c;
    req.addr = a;
    req.wdata = w;
    req.start_addr = s;
    req.end_addr = e;
    @(negedge clk);
    // Released address, data and range fields show inverted values so stale data cannot pass
    req.valid = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
    req.start_addr = ~req.start_addr;
    req.end_addr = ~req.end_addr;
  endtask
endmodule
`default_nettype wire

// File: tb_crc_status_and_config_reg1.sv
// Self-checking bench for the CRC status and config-one register logic.
// Assumes the host model in its own file and the design package.
`timescale 1ns/1ps
`default_nettype none
module tb_crc_status_and_config_reg1;
  import crcsr_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hw_pulse = 1'b0;
  logic sw_pulse = 1'b0;
  logic crc_done = 1'b0;
  crcsr_req_s req;
  crcsr_rsp_s rsp;
  logic busy_flag;
  logic [3:0] lat;
  logic quad;
  logic running;
  logic start_ok;
  logic [7:0] sr2;
  // Good CRC starts seen on the accept strobe
  int starts_seen = 0;
  int err_total = 0;
  int samples_checked = 0;

  // Request source standing in for the host
  crcsr_host_model crcsr_host_model_inst (.clk(clk), .req(req));

  crcsr_top crcsr_top_inst (
    .clk(clk), .reset_n(reset_n), .hw_reset_pulse(hw_pulse), .sw_reset_pulse(sw_pulse),
    .crc_done(crc_done), .req(req), .rsp(rsp), .busy_flag(busy_flag),
    .read_latency_code(lat), .quad_io_en(quad), .crc_running(running),
    .crc_start_ok(start_ok), .status_reg_two(sr2)
  );

  // Count accepted starts at the edge that takes them
  always @(posedge clk) begin
    if (start_ok === 1'b1) begin
      starts_seen++;
    end
  end

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // Byte comparison, bits are zero-extended by the caller
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Status byte and busy together
  task automatic chk_st(input logic [7:0] s, input logic b);
    chk8(sr2, s, "status two");
    chk8({7'h0, busy_flag}, {7'h0, b}, "busy");
  endtask

  task automatic op(input crcsr_cmd_e c, input logic [23:0] a, input logic [7:0] w);
    crcsr_host_model_inst.issue(c, a, w, 18'h0_0000, 18'h0_0000);
  endtask

  task automatic crc(input logic [17:0] s, input logic [17:0] e);
    crcsr_host_model_inst.issue(CRCSR_CMD_CRC_START, 24'h00_0000, 8'h00, s, e);
  endtask

  // Read and check the answer in the cycle it stands
  task automatic rd(input crcsr_cmd_e c, input logic [23:0] a, input logic h,
                    input logic [7:0] d);
    op(c, a, 8'h00);
    chk8({7'h0, rsp.valid}, 8'h01, "rsp valid");
    chk8({7'h0, rsp.hit}, {7'h0, h}, "rsp hit");
    chk8(rsp.data, d, "rsp data");
  endtask

  // One-cycle pulse on a reset or done input
  task automatic pulse(input int which);
    @(negedge clk);
    if (which == 0) hw_pulse = 1'b1;
    else if (which == 1) sw_pulse = 1'b1;
    else crc_done = 1'b1;
    @(negedge clk);
    hw_pulse = 1'b0;
    sw_pulse = 1'b0;
    crc_done = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #8000;
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(posedge clk);
    chk_st(8'h00, 1'b0);
    rd(CRCSR_CMD_READ_CR1, 24'h00_0000, 1'b1, CR_FACTORY);
    rd(CRCSR_CMD_READ_ANY, 24'h00_0050, 1'b0, 8'h00);
    $display("test reset_values done");
    op(CRCSR_CMD_WRITE_ANY, ADDR_CR1_NV, 8'h62);
    @(negedge clk);
    chk8({4'h0, lat}, 8'h06, "latency");
    chk8({7'h0, quad}, 8'h01, "quad");
    rd(CRCSR_CMD_READ_ANY, ADDR_CR1_V, 1'b1, 8'h62);
    op(CRCSR_CMD_WRITE_ANY, ADDR_CR1_V, 8'hFF);
    rd(CRCSR_CMD_READ_ANY, ADDR_CR1_NV, 1'b1, 8'hF2);
    chk8({4'h0, lat}, 8'h0F, "latency volatile");
    $display("test config_write done");
    crc(18'h0_0010, 18'h0_0012);
    chk_st(8'h08, 1'b0);
    crc(18'h0_0010, 18'h0_0013);
    chk_st(8'h00, 1'b1);
    chk8({7'h0, running}, 8'h01, "running after start");
    rd(CRCSR_CMD_READ_ANY, ADDR_CR1_V, 1'b0, 8'h00);
    rd(CRCSR_CMD_READ_ANY, ADDR_SR2_V, 1'b1, 8'h00);
    op(CRCSR_CMD_CRC_PAUSE, 24'h00_0000, 8'h00);
    chk_st(8'h10, 1'b1);
    op(CRCSR_CMD_WRITE_ANY, ADDR_SR2_NV, 8'hFF);
    rd(CRCSR_CMD_READ_SR2, 24'h00_0000, 1'b1, 8'h10);
    op(CRCSR_CMD_CRC_CONT, 24'h00_0000, 8'h00);
    chk_st(8'h00, 1'b1);
    chk8({7'h0, running}, 8'h01, "running after continue");
    pulse(2);
    chk_st(8'h00, 1'b0);
    op(CRCSR_CMD_CRC_PAUSE, 24'h00_0000, 8'h00);
    chk_st(8'h00, 1'b0);
    $display("test crc_flags done");
    crc(18'h3_FFF0, 18'h3_FFEF);
    chk_st(8'h08, 1'b0);
    pulse(1);
    chk_st(8'h00, 1'b0);
    rd(CRCSR_CMD_READ_CR1, 24'h00_0000, 1'b1, 8'hF2);
    crc(18'h0_0000, 18'h0_0100);
    op(CRCSR_CMD_CRC_PAUSE, 24'h00_0000, 8'h00);
    chk_st(8'h10, 1'b1);
    pulse(0);
    chk_st(8'h00, 1'b0);
    rd(CRCSR_CMD_READ_ANY, ADDR_CR1_V, 1'b1, 8'h62);
    chk8({4'h0, lat}, 8'h06, "latency reload");
    chk8({7'h0, running}, 8'h00, "running after reset");
    chk8(starts_seen[7:0], 8'h02, "good starts");
    $display("test resets done");
    complete_run();
  end
endmodule
`default_nettype wire
